//--- inc/psm_defs.vh
// constants for the power-saving mode controller
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH
`define PSM_ADDR_POWER_CONTROL 8'h87
`define PSM_RESET_POWER_CONTROL 8'h00
`define PSM_BIT_IDLE 0
`define PSM_BIT_POWERDOWN 1
`define PSM_BIT_UART2_TX_CLK 2
`define PSM_BIT_UART2_RX_CLK 3
`define PSM_BIT_ADC_IRQ_EN 4
`define PSM_BIT_LVR_DISABLE 5
`define PSM_BIT_UART2_DOUBLE 6
`define PSM_BIT_UART_DOUBLE 7
`define PSM_MACHINE_CYCLE_CLKS 12
`define PSM_RESTART_MACHINE_CYCLES 3
`define PSM_RESTART_CLKS (`PSM_RESTART_MACHINE_CYCLES * `PSM_MACHINE_CYCLE_CLKS)
`endif

//--- rtl/psm_power_control.v
// power-saving mode controller with power control register
//
// Functional notes
// - writing bit 0 enters idle, cpu halted
// - writing bit 1 enters power-down
// - idle-setting instruction is last one executed
// - peripherals keep running during idle
// - cpu state held unchanged while idle
// - enabled interrupt clears idle bit in hardware
// - resume after instruction that set idle
// - internal reset restarts after 3 machine cycles
// - power-down stops the oscillator
// - ram and registers kept in power-down
// - only reset exits power-down
// - low-voltage detector active in power-down
// - power-down disables pwm, i2c, display channel, usb
// - register at 87 hex, resets to 00
// - bit 5 disables low-voltage reset
// - bit 4 enables adc interrupt
// - bits 7 and 6 double uart baud
// - bits 3 and 2 select uart2 clocks
// - low-voltage reset enabled after power-up
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`include "psm_defs.vh"

module psm_power_control (
  // clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // register port
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrStb,
  input  wire       regRdStb,
  output reg  [7:0] regRdData,
  // core handshake
  input  wire       instrRetire,
  input  wire       irqPending,
  input  wire       internalReset,
  // low-voltage detector
  input  wire       lowVoltageDetect,
  // control outputs
  output wire       cpuRun,
  output wire       cpuHold,
  output wire       oscEnable,
  output wire       periphEnable,
  output wire       portsHold,
  output wire       lowVoltageReset,
  output wire       uartBaudDouble,
  output wire       uart2BaudDouble,
  output wire       adcIrqEnable,
  output wire       uart2RxClockSelect,
  output wire       uart2TxClockSelect,
  output wire       idleActive,
  output wire       powerdownActive
);

  // ==========================================================
  // state encoding
  localparam [3:0] ST_RUN     = 4'h1;
  localparam [3:0] ST_IDLE    = 4'h2;
  localparam [3:0] ST_PDOWN   = 4'h4;
  localparam [3:0] ST_RESTART = 4'h8;
  // restart hold length, loaded then counted down to zero
  localparam integer RESTART_LOAD = `PSM_RESTART_CLKS - 1;

  function hitReg;
    input [7:0] a;
    begin
      hitReg = (a == `PSM_ADDR_POWER_CONTROL);
    end
  endfunction

  reg [7:0] powerControl;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [5:0] restartCnt;
  reg       lowVoltMeta;
  reg       lowVoltSync;
  reg       irqMeta;
  reg       irqSync;
  wire      wrHit = regWrStb && hitReg(regAddr);

  // ==========================================================
  // input synchronisers
  always @(posedge clk) begin
    if (!rst_b) begin
      lowVoltMeta <= 1'b0;
      lowVoltSync <= 1'b0;
      irqMeta     <= 1'b0;
      irqSync     <= 1'b0;
    end else begin
      lowVoltMeta <= lowVoltageDetect;
      lowVoltSync <= lowVoltMeta;
      irqMeta <= irqPending;
      irqSync <= irqMeta;
    end
  end

  // ==========================================================
  // power control register
  always @(posedge clk) begin
    if (!rst_b || internalReset) begin
      powerControl <= `PSM_RESET_POWER_CONTROL;
    end else if (state == ST_PDOWN) begin
      powerControl <= powerControl;
    end else if (wrHit) begin
      powerControl <= regWrData;
      if (state == ST_IDLE && irqSync)
        powerControl[`PSM_BIT_IDLE] <= 1'b0;
    end else if (state == ST_IDLE && irqSync) begin
      powerControl[`PSM_BIT_IDLE] <= 1'b0;
    end
  end

  // ==========================================================
  // mode sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (powerControl[`PSM_BIT_POWERDOWN] && instrRetire)
          next_state = ST_PDOWN;
        else if (powerControl[`PSM_BIT_IDLE] && instrRetire)
          next_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (!powerControl[`PSM_BIT_IDLE])
          next_state = ST_RUN;
      end
      ST_PDOWN:   next_state = ST_PDOWN;
      ST_RESTART: begin
        if (restartCnt == 6'd0)
          next_state = ST_RUN;
      end
      default:    next_state = ST_RUN;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      state      <= ST_RUN;
      restartCnt <= 6'd0;
    end else if (internalReset) begin
      state      <= ST_RESTART;
      restartCnt <= RESTART_LOAD[5:0];
    end else begin
      state <= next_state;
      if (state == ST_RESTART && restartCnt != 6'd0)
        restartCnt <= restartCnt - 6'd1;
    end
  end

  // ==========================================================
  // register read port
  always @(posedge clk) begin
    if (!rst_b)
      regRdData <= 8'h00;
    else if (regRdStb && hitReg(regAddr))
      regRdData <= powerControl;
    else
      regRdData <= 8'h00;
  end

  // ==========================================================
  // outputs
  assign idleActive      = (state == ST_IDLE);
  assign powerdownActive = (state == ST_PDOWN);
  // cpu halted and state held while idle or down
  assign cpuHold         = (state != ST_RUN);
  // set idle or power-down bit stops issue after current instruction
  assign cpuRun          = (state == ST_RUN) && !(instrRetire &&
                           (powerControl[`PSM_BIT_IDLE] ||
                            powerControl[`PSM_BIT_POWERDOWN]));
  assign oscEnable       = !powerdownActive;
  assign periphEnable    = !powerdownActive;
  assign portsHold       = cpuHold;
  assign lowVoltageReset = lowVoltSync &&
                           !powerControl[`PSM_BIT_LVR_DISABLE];
  assign uartBaudDouble     = powerControl[`PSM_BIT_UART_DOUBLE];
  assign uart2BaudDouble    = powerControl[`PSM_BIT_UART2_DOUBLE];
  assign adcIrqEnable       = powerControl[`PSM_BIT_ADC_IRQ_EN];
  assign uart2RxClockSelect = powerControl[`PSM_BIT_UART2_RX_CLK];
  assign uart2TxClockSelect = powerControl[`PSM_BIT_UART2_TX_CLK];

endmodule // psm_power_control

//--- tb/psm_power_control_asserts.sv
// port assertions for the power control block
`timescale 1ns/1ps
module psm_power_control_asserts (
  input wire       clk, rst_b, regWrStb, regRdStb, irqPending, internalReset,
  input wire [7:0] regAddr, regWrData, regRdData,
  input wire       oscEnable, periphEnable, cpuHold, portsHold, idleActive,
  input wire       powerdownActive, lowVoltageReset, uartBaudDouble
);
  // ====================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire wrHit = regWrStb && regAddr == 8'h87 && !powerdownActive && !internalReset;
  property p_rd; regRdStb && regAddr != 8'h87 |=> regRdData == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("unmapped read not zero");
  property p_osc; powerdownActive |-> !oscEnable && !periphEnable; endproperty
  a_osc: assert property (p_osc) else $error("clock running in power-down");
  property p_ports; (idleActive || powerdownActive) |-> portsHold && cpuHold; endproperty
  a_ports: assert property (p_ports) else $error("ports not held in low-power mode");
  property p_stay; powerdownActive && !internalReset |=> powerdownActive; endproperty
  a_stay: assert property (p_stay) else $error("power-down left without reset");
  property p_idle; idleActive |-> cpuHold && oscEnable && periphEnable; endproperty
  a_idle: assert property (p_idle) else $error("idle state wrong");
  property p_baud; wrHit && regWrData[7] |=> uartBaudDouble; endproperty
  a_baud: assert property (p_baud) else $error("baud double not set");
  property p_lvr; wrHit && regWrData[5] |=> !lowVoltageReset; endproperty
  a_lvr: assert property (p_lvr) else $error("low-voltage reset not disabled");
  property p_wake; idleActive && irqPending |-> ##[1:5] !idleActive; endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not end idle");
  property p_rst; $rose(rst_b) |-> !idleActive && !powerdownActive && oscEnable; endproperty
  a_rst: assert property (p_rst) else $error("reset left a mode active");
  c_idle: cover property ($rose(idleActive));
  c_pd: cover property ($rose(powerdownActive));
  c_wake: cover property ($fell(idleActive));
endmodule // psm_power_control_asserts

//--- tb/psm_power_control_tb_top.sv
// self-checking bench for the power control block
`timescale 1ns/1ps
module psm_power_control_tb_top;
  reg clk = 0, rst_b = 0, regWrStb = 0, regRdStb = 0, instrRetire = 0, rdSeen = 0;
  reg irqPending = 0, internalReset = 0, lowVoltageDetect = 1;
  reg [7:0] regAddr = 0, regWrData = 0, d, q[$];
  wire [7:0] regRdData;
  wire cpuRun, cpuHold, oscEnable, periphEnable, portsHold, lowVoltageReset, uartBaudDouble;
  wire uart2BaudDouble, adcIrqEnable, uart2RxClockSelect, uart2TxClockSelect;
  wire idleActive, powerdownActive;
  integer n_mismatch = 0, tests_run = 0, seed = 93337, i, n;
  always #4 clk = ~clk;
  psm_power_control DUT (.clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .instrRetire, .irqPending, .internalReset, .lowVoltageDetect, .cpuRun,
    .cpuHold, .oscEnable, .periphEnable, .portsHold, .lowVoltageReset, .uartBaudDouble,
    .uart2BaudDouble, .adcIrqEnable, .uart2RxClockSelect, .uart2TxClockSelect,
    .idleActive, .powerdownActive);
  // ====================
  // tasks and monitor
  task chk(input [7:0] seen, exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task acc(input w, input [7:0] a, dat);
    @(posedge clk);
    regAddr <= a;
    regWrData <= dat;
    regWrStb <= w;
    regRdStb <= !w;
    if (!w) q.push_back(dat);
    @(posedge clk);
    regWrStb <= 0;
    regRdStb <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task retire;
    @(posedge clk) instrRetire <= 1;
    #1 chk(cpuRun, 0);
    @(posedge clk) instrRetire <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    if (rdSeen) chk(regRdData, q.pop_front());
    rdSeen <= regRdStb;
  end
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    acc(0, 8'h87, 8'h00);
    chk(lowVoltageReset, 1);
    for (i = 0; i < 8; i = i + 1) begin
      d = $random(seed) & 8'hfc;
      acc(1, 8'h87, d);
      acc(0, 8'h87, d);
      acc(0, {1'b0, d[7:1]}, 8'h00);
      chk({uartBaudDouble, uart2BaudDouble, !lowVoltageReset, adcIrqEnable,
        uart2RxClockSelect, uart2TxClockSelect}, d[7:2]);
    end
    $display("registers done");
    acc(1, 8'h87, 8'h01);
    retire;
    chk({idleActive, cpuHold, oscEnable, periphEnable, portsHold, cpuRun}, 8'h3e);
    @(posedge clk) irqPending <= 1;
    repeat (6) @(posedge clk);
    #1 chk({idleActive, cpuHold, cpuRun}, 8'h01);
    @(posedge clk) irqPending <= 0;
    acc(0, 8'h87, 8'h00);
    $display("idle done");
    acc(1, 8'h87, 8'h02);
    retire;
    chk({powerdownActive, oscEnable, periphEnable, lowVoltageReset}, 8'h09);
    @(posedge clk) lowVoltageDetect <= 0;
    repeat (3) @(posedge clk);
    #1 chk(lowVoltageReset, 0);
    @(posedge clk) irqPending <= 1;
    lowVoltageDetect <= 1;
    acc(1, 8'h87, 8'h00);
    acc(0, 8'h87, 8'h02);
    chk(powerdownActive, 1);
    @(posedge clk) irqPending <= 0;
    rst_b <= 0;
    repeat (24) @(posedge clk);
    rst_b <= 1;
    acc(0, 8'h87, 8'h00);
    chk(powerdownActive, 0);
    $display("power-down done");
    acc(1, 8'h87, 8'h01);
    retire;
    @(posedge clk) internalReset <= 1;
    @(posedge clk) internalReset <= 0;
    n = 0;
    while (cpuHold === 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    chk(n, 36);
    chk(idleActive, 0);
    acc(0, 8'h87, 8'h00);
    $display("restart done");
    conclude;
  end
endmodule // psm_power_control_tb_top
bind psm_power_control psm_power_control_asserts u_chk (.clk, .rst_b, .regWrStb, .regRdStb,
  .irqPending, .internalReset, .regAddr, .regWrData, .regRdData, .oscEnable, .periphEnable,
  .cpuHold, .portsHold, .idleActive, .powerdownActive, .lowVoltageReset, .uartBaudDouble);
